// File: hdl/cascaded_interval_timer.sv
// Three 16-bit down counters: one uncommitted, two chained into a 32-bit timer.
// Assumes connector clock and gate pins are asynchronous; firmware side is on clk.
//
// How it works
// - Three 16-bit counters each count down from their loaded value; counter two is clocked by counter one.
// - Counter zero is gated by an input and clocked by counter one or an external clock.
// - Counter zero's clock, gate and output all appear on the connector pins.
// - Counters one and two are fixed in a chain that acts as one 32-bit timer.
// - Counter one counts a 10 MHz on-board rate and may be enabled by a gate input.
// - Counter one's output clocks counter two and is driven to the connector.
// - Counter two's output drives the microcontroller timer input.
// - Every counter decrements on the falling edge of its count clock.
// - A conversion start comes from a software command or a timer pulse.
module cascaded_interval_timer
    import interval_timer_pkg::*;
(
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // Counter loads from firmware
    input  wire interval_timer_pkg::load_req_t   load0,
    input  wire interval_timer_pkg::load_req_t   load1,
    input  wire interval_timer_pkg::load_req_t   load2,
    input  wire interval_timer_pkg::clk_src_t    ctr0Src,
    // Connector pins
    input  wire interval_timer_pkg::ext_pins_t   extPins,
    input  wire logic                            ctr1Gate,
    output logic                                 ctr0Out,
    output logic                                 ctr1Out,
    // Microcontroller and converter
    output logic                                 mcu_timer_input,
    input  wire interval_timer_pkg::trig_src_t   trigSrc,
    input  wire logic                            softStart,
    output logic                                 convStart,
    // Observed counts
    output logic [15:0]                          count0,
    output logic [31:0]                          timerCount
);
    import interval_timer_pkg::*;

    // Synchronisers for asynchronous pins
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    logic       extClkS;
    logic       extGateS;
    logic       gate1S;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
        end
        else
        begin
            syncA_reg <= {ctr1Gate, extPins.gateIn, extPins.clkIn};
            syncB_reg <= syncA_reg;
        end
    end

    assign extClkS  = syncB_reg[0];
    assign extGateS = syncB_reg[1];
    assign gate1S   = syncB_reg[2];

    // 10 MHz oscillator as a square wave, so counter one sees real falling edges
    logic [2:0] divCnt_reg;
    logic       osc_reg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            divCnt_reg <= 3'h0;
            osc_reg    <= 1'b0;
        end
        else if (divCnt_reg == OSC_DIV_LAST)
        begin
            divCnt_reg <= 3'h0;
            osc_reg    <= 1'b0;
        end
        else
        begin
            divCnt_reg <= divCnt_reg + 3'h1;
            if (divCnt_reg == 3'h1)
                osc_reg <= 1'b1;
        end
    end

    // Counter outputs: a level toggled at each terminal count
    logic       out1_reg;
    logic       out2_reg;
    logic       out0_reg;
    logic       term0;
    logic       term1;
    logic       term2;
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic       clk0Sel;

    // Counter one: oscillator clock, optional gate
    down_counter u_ctr1
    (
        .clk      (clk),
        .rstn     (rstn),
        .load     (load1),
        .gate     (gate1S),
        .cntClk   (osc_reg),
        .count    (cnt1),
        .terminal (term1)
    );

    // Counter two: clocked only by counter one's output, never a free source
    down_counter u_ctr2
    (
        .clk      (clk),
        .rstn     (rstn),
        .load     (load2),
        .gate     (1'b1),
        .cntClk   (out1_reg),
        .count    (cnt2),
        .terminal (term2)
    );

    // Counter zero clock mux; external rate is limited by the sampling to below 25 MHz
    assign clk0Sel = (ctr0Src == SRC_EXTERNAL) ? extClkS : out1_reg;

    down_counter u_ctr0
    (
        .clk      (clk),
        .rstn     (rstn),
        .load     (load0),
        .gate     (extGateS),
        .cntClk   (clk0Sel),
        .count    (count0),
        .terminal (term0)
    );

    always_ff @(posedge clk)
    begin
        if (!rstn)
            out1_reg <= 1'b1;
        else if (load1.strobe)
            out1_reg <= 1'b1;
        else if (term1)
            out1_reg <= ~out1_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            out2_reg <= 1'b1;
        else if (load2.strobe)
            out2_reg <= 1'b1;
        else if (term2)
            out2_reg <= ~out2_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            out0_reg <= 1'b1;
        else if (load0.strobe)
            out0_reg <= 1'b1;
        else if (term0)
            out0_reg <= ~out0_reg;
    end

    // Registered outputs
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctr0Out         <= 1'b1;
            ctr1Out         <= 1'b1;
            mcu_timer_input <= 1'b1;
            timerCount      <= 32'h00000000;
        end
        else
        begin
            ctr0Out         <= out0_reg;
            ctr1Out         <= out1_reg;
            mcu_timer_input <= out2_reg;
            timerCount      <= {cnt2, cnt1};
        end
    end

    // Conversion start: softStart level registered, or a one-cycle pulse at timer terminal count
    always_ff @(posedge clk)
    begin
        if (!rstn)
            convStart <= 1'b0;
        else if (trigSrc == TRIG_TIMER)
            convStart <= term2;
        else
            convStart <= softStart;
    end

endmodule // cascaded_interval_timer

// File: inc/interval_timer_pkg.sv
// Package for the cascaded interval timer: widths, reset values, clock timing.
// Assumes a single 50 MHz system clock; all link clocks are sampled.
package interval_timer_pkg;

    localparam int CNT_W = 16;

    // Value after reset of every counter
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // System clock and the on-board count oscillator
    localparam int SYS_CLK_HZ = 50_000_000;
    localparam int OSC_HZ     = 10_000_000;
    // Divider period for the 10 MHz square wave, in system cycles
    localparam int OSC_DIV    = SYS_CLK_HZ / OSC_HZ;
    localparam logic [2:0] OSC_DIV_LAST = 3'(OSC_DIV - 1);

    // Clock source choices for counter zero
    typedef enum logic [0:0]
    {
        SRC_CASCADE  = 1'b0,
        SRC_EXTERNAL = 1'b1
    } clk_src_t;

    // Conversion start choices
    typedef enum logic [0:0]
    {
        TRIG_SOFTWARE = 1'b0,
        TRIG_TIMER    = 1'b1
    } trig_src_t;

    // Load request from the microcontroller side, one per counter
    typedef struct packed
    {
        logic        strobe;
        logic [15:0] value;
    } load_req_t;

    // Connector-side inputs of counter zero
    typedef struct packed
    {
        logic clkIn;
        logic gateIn;
    } ext_pins_t;

endpackage : interval_timer_pkg

// File: hdl/down_counter.sv
// One 16-bit down counter with load, gate and falling-edge count.
// Assumes the count clock arrives already synchronised as a level.
module down_counter
    import interval_timer_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // Control
    input  wire interval_timer_pkg::load_req_t load,
    input  wire logic                        gate,
    input  wire logic                        cntClk,
    // State
    output logic [interval_timer_pkg::CNT_W-1:0] count,
    output logic                             terminal
);
    import interval_timer_pkg::*;

    logic cntClkPrev_reg;
    logic fallEdge;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            cntClkPrev_reg <= 1'b0;
        else
            cntClkPrev_reg <= cntClk;
    end

    // High-to-low transition of the count clock
    assign fallEdge = cntClkPrev_reg & ~cntClk;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            count    <= CNT_RESET;
            terminal <= 1'b0;
        end
        else if (load.strobe)
        begin
            count    <= load.value;
            terminal <= 1'b0;
        end
        else if (fallEdge && gate)
        begin
            // Wraps through zero, so a zero load gives a full 65536 period
            count    <= count - 16'h0001;
            terminal <= (count == 16'h0001);
        end
        else
            terminal <= 1'b0;
    end

endmodule // down_counter

// File: test/cascaded_interval_timer_asserts.sv
// Checker on the timer ports: loads, counts, gates, starts.
// Assumes one clock domain; bound into every timer instance.
module cascaded_interval_timer_asserts
(
    // Clock and reset
    input logic                          clk,
    input logic                          rstn,
    // Inputs
    input interval_timer_pkg::load_req_t load0,
    input interval_timer_pkg::load_req_t load1,
    input interval_timer_pkg::load_req_t load2,
    input interval_timer_pkg::ext_pins_t extPins,
    input logic                          ctr1Gate,
    input interval_timer_pkg::trig_src_t trigSrc,
    input logic                          softStart,
    // Outputs
    input logic                          mcu_timer_input,
    input logic                          convStart,
    input logic [15:0]                   count0,
    input logic [31:0]                   timerCount
);
    timeunit 1ns;
    timeprecision 1ns;
    import interval_timer_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    reset_vals_a: assert property (disable iff (1'b0) !rstn |=> count0 == 16'h0000
        && mcu_timer_input && !convStart) else $error("reset");
    load_take_a: assert property (load0.strobe |=> count0 == $past(load0.value))
        else $error("load0");
    step_zero_a: assert property ($changed(count0) && !$past(load0.strobe) |->
        count0 == $past(count0) - 16'h0001) else $error("step0");
    hold_zero_a: assert property ((!extPins.gateIn && !load0.strobe) [*8] |=>
        $stable(count0)) else $error("hold0");
    hold_one_a: assert property ((!ctr1Gate && !load1.strobe) [*8] |=>
        $stable(timerCount[15:0])) else $error("hold1");
    step_one_a: assert property ($changed(timerCount[15:0]) && !$past(load1.strobe)
        && !$past(load1.strobe, 2) |-> timerCount[15:0] == $past(timerCount[15:0]) - 16'h0001)
        else $error("step1");
    mcu_zero_a: assert property ($changed(mcu_timer_input) && !$past(load2.strobe)
        && !$past(load2.strobe, 2) |-> timerCount[31:16] == 16'h0000) else $error("mcu");
    soft_start_a: assert property (!trigSrc && !$past(trigSrc) |->
        convStart == $past(softStart)) else $error("soft");
    conv_seen_c: cover property (convStart);
    mcu_low_c: cover property (!mcu_timer_input);
    gate_hold_c: cover property (!ctr1Gate [*8]);
endmodule // cascaded_interval_timer_asserts
bind cascaded_interval_timer cascaded_interval_timer_asserts chk_i (.*);

// File: test/ext_source.sv
// Model of the connector clock and gate that feed counter zero.
// Assumes go is held until busy answers; the clock rests low between bursts.
module ext_source
(
    // Clock and control
    input  logic                          clk,
    input  logic                          go,
    input  logic                          gate,
    // Connector pins
    output interval_timer_pkg::ext_pins_t extPins,
    output logic                          busy
);
    timeunit 1ns;
    timeprecision 1ns;
    import interval_timer_pkg::*;
    initial
    begin
        extPins = '0;
        busy = 1'b0;
        forever
        begin
            @(negedge clk);
            extPins.gateIn = gate;
            if (go)
            begin
                busy = 1'b1;
                // Eight-cycle period clears the pin sync minimum
                repeat (5)
                begin
                    extPins.clkIn = 1'b1;
                    repeat (4) @(negedge clk);
                    extPins.clkIn = 1'b0;
                    repeat (4) @(negedge clk);
                end
                busy = 1'b0;
            end
        end
    end
endmodule // ext_source

// File: test/cascaded_interval_timer_bench.sv
// Self-checking bench for the cascaded interval timer.
// Assumes the partner model drives the pins of counter zero.
module cascaded_interval_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import interval_timer_pkg::*;
    logic        clk, rstn, ctr1Gate, softStart, go, gate, busy;
    logic        ctr0Out, ctr1Out, mcu_timer_input, convStart;
    load_req_t   load0, load1, load2;
    clk_src_t    ctr0Src;
    trig_src_t   trigSrc;
    ext_pins_t   extPins;
    logic [15:0] count0, v;
    logic [31:0] timerCount;
    int          n_mismatch, compares, n;
    cascaded_interval_timer uut (.*);
    ext_source partner (.*);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task automatic wrap_up;
        $display("Compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic await(input logic want);
        for (int i = 0; i < 200 && busy !== want; i++)
            cyc(1);
        if (busy !== want)
        begin
            chk(1'b0, "timeout");
            wrap_up();
        end
    endtask
    // Counts the cycles in which convStart is high over k cycles
    task automatic starts(input int k);
        repeat (k)
        begin
            cyc(1);
            n += int'(convStart === 1'b1);
        end
    endtask
    task automatic t_ext;
        load0 = '{1'b1, 16'h0003};
        cyc(1);
        load0.strobe = 1'b0;
        chk(count0 === 16'h0003, "load0");
        cyc(60);
        chk(count0 === 16'h0003, "hold0");
        ctr0Src = SRC_EXTERNAL;
        gate = 1'b1;
        go = 1'b1;
        await(1'b1);
        go = 1'b0;
        await(1'b0);
        cyc(8);
        gate = 1'b0;
        chk(count0 === 16'hfffe && ctr0Out === 1'b0, "ext");
    endtask
    task automatic t_chain;
        n = 0;
        trigSrc = TRIG_TIMER;
        load1 = '{1'b1, 16'h0002};
        load2 = '{1'b1, 16'h0001};
        cyc(1);
        load1.strobe = 1'b0;
        load2.strobe = 1'b0;
        starts(80);
        chk(n == 1 && ctr1Out === 1'b0, "cascade");
        chk(mcu_timer_input === 1'b0 && timerCount[31:16] === 16'h0000, "mcu");
        ctr1Gate = 1'b0;
        cyc(10);
        v = timerCount[15:0];
        cyc(40);
        chk(timerCount[15:0] === v, "hold1");
        ctr1Gate = 1'b1;
        cyc(10);
        v = timerCount[15:0];
        cyc(100);
        chk(timerCount[15:0] === v - 16'h0014, "rate");
    endtask
    task automatic t_soft;
        n = 0;
        trigSrc = TRIG_SOFTWARE;
        cyc(3);
        softStart = 1'b1;
        starts(2);
        softStart = 1'b0;
        starts(4);
        chk(n == 2, "soft");
    endtask
    initial
    begin
        {rstn, go, gate, softStart} = '0;
        {load0, load1, load2} = '0;
        ctr1Gate = 1'b1;
        ctr0Src = SRC_CASCADE;
        trigSrc = TRIG_SOFTWARE;
        n_mismatch = 0;
        compares = 0;
        cyc(16);
        rstn = 1'b1;
        chk(count0 === 16'h0000 && mcu_timer_input === 1'b1, "reset");
        t_ext();
        t_chain();
        t_soft();
        rstn = 1'b0;
        cyc(3);
        rstn = 1'b1;
        chk(count0 === 16'h0000 && ctr0Out === 1'b1, "reset2");
        wrap_up();
    end
endmodule // cascaded_interval_timer_bench
